// ==== core/ledfc_pkg.sv ====
// ledfc_pkg: register map, field layout and reset values of the led function-control bank
package ledfc_pkg;

   // bus geometry
   localparam int ADDR_W = 5;                     // byte address width
   localparam int DATA_W = 32;                    // wishbone data width
   localparam int REG_W  = 48;                    // width of each control register
   localparam int LINE_W = 5;                     // scan line index for the stacked pair

   // byte offsets of the 32-bit windows
   localparam logic [ADDR_W-1:0] OFS_TUNE_LO = 5'h00;   // tuning bits 31..0
   localparam logic [ADDR_W-1:0] OFS_TUNE_HI = 5'h04;   // tuning bits 47..32
   localparam logic [ADDR_W-1:0] OFS_LSEL_LO = 5'h08;   // line select bits 31..0
   localparam logic [ADDR_W-1:0] OFS_LSEL_HI = 5'h0C;   // line select bits 47..32
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 5'h10;   // derived state, read only

   // writable bits and reset images of the tuning register
   localparam logic [REG_W-1:0] TUNE_WMASK = 48'h1FFF_0FFF_4002;
   localparam logic [REG_W-1:0] TUNE_RST   = 48'h0800_0540_403C;
   // writable bits and reset image of the line select register
   localparam logic [REG_W-1:0] LSEL_WMASK = 48'h0000_0000_003F;
   localparam logic [REG_W-1:0] LSEL_RST   = 48'h0000_0000_0000;

   // field positions inside the tuning register
   localparam int CEIL_POS   = 1;                 // current ceiling select
   localparam int SCAN_POS   = 14;                // upper line order reverse
   localparam int FINE_POS   = 16;                // fine range enables r,g,b
   localparam int TOFF_POS   = 19;                // turn-off slew r,g,b
   localparam int TON_POS    = 22;                // turn-on slew, two bits per colour
   localparam int COARSE_POS = 32;                // coarse range enables r,g,b
   localparam int DIM_POS    = 35;                // first line dimming code
   localparam int ISO_POS    = 39;                // on/off channel isolation enable
   localparam int BOOST_POS  = 40;                // isolation boost code
   localparam int BOOSTEN_POS = 44;               // isolation boost enable
   localparam int ROW_POS    = 0;                 // open-load row select in second reg
   localparam int ROW_W      = 6;                 // row select width
   localparam int CODE_W     = 4;                 // dimming and boost code width

   // scan order constants for the upper device
   localparam logic [LINE_W-1:0] UPPER_FIRST = 5'h10;  // first upper line
   localparam logic [LINE_W-1:0] UPPER_LAST  = 5'h1F;  // last upper line

   // status word layout
   localparam int ST_BOOST_POS = 0;               // applied boost level, 0 = off
   localparam int ST_DIM_POS   = 5;               // applied dimming level 1..16
   localparam int ST_LINE_POS  = 10;              // last mapped scan line
   localparam int ST_CEIL_POS  = 15;              // current ceiling in use

   // turn-on slew codes
   typedef enum logic [1:0] {
      ledfc_slew_slowest = 2'h0,
      ledfc_slew_slow    = 2'h1,
      ledfc_slew_fast    = 2'h2,
      ledfc_slew_fastest = 2'h3
   } ledfc_slew_e;

   // decoded tuning controls handed to the analog side
   typedef struct packed {
      logic                     current_ceiling_select;
      logic                     upper_scan_order_reverse;
      logic [2:0]               fine_range_enable;
      logic                     red_turnoff_slew;
      logic                     green_turnoff_slew;
      logic                     blue_turnoff_slew;
      ledfc_slew_e              red_turnon_slew;
      ledfc_slew_e              green_turnon_slew;
      ledfc_slew_e              blue_turnon_slew;
      logic [2:0]               coarse_range_enable;
      logic                     on_off_channel_isolation_enable;
   } ledfc_tuning_s;

endpackage

// ==== core/ledfc_wb_slave.sv ====
// ledfc_wb_slave: classic wishbone handshake, one wait state, acknowledge generation
module ledfc_wb_slave (
   // clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   // wishbone request
   input  wire logic wb_cyc_i,
   input  wire logic wb_stb_i,
   input  wire logic wb_we_i,
   // handshake results
   output logic      wb_ack_o,
   output logic      take_read,
   output logic      take_write
);

   logic req;                                     // live request this cycle

   // a request counts while cycle and strobe are both high
   assign req = wb_cyc_i & wb_stb_i;

   // ack one cycle after the request, dropped in the cycle after
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
      end
   end

   // read data is captured on the request cycle before ack
   assign take_read = req & ~wb_ack_o & ~wb_we_i;

   // write commits on the edge where ack is seen high
   assign take_write = req & wb_ack_o & wb_we_i;

endmodule

// ==== core/ledfc_scan_map.sv ====
// ledfc_scan_map: logical to physical scan line translation for the stacked pair
module ledfc_scan_map #(
   parameter int LINE_W = ledfc_pkg::LINE_W
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              nrst,
   // control and line in
   input  wire logic              reverse,
   input  wire logic [LINE_W-1:0] line_in,
   // translated line
   output logic      [LINE_W-1:0] line_out
);

   logic [LINE_W-1:0] next_line;                  // combinational translation
   logic              upper;                      // line sits on upper device

   // upper lines are 16..31; reversal mirrors them inside that half
   always_comb begin
      upper     = line_in >= ledfc_pkg::UPPER_FIRST;
      next_line = line_in;
      if (upper && reverse) begin
         // 16->31, 31->16: same for scan and memory read sequence
         next_line = LINE_W'(ledfc_pkg::UPPER_FIRST + ledfc_pkg::UPPER_LAST - line_in);
      end
   end

   // registered so the sequencer sees a clean value
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         line_out <= '0;
      end else begin
         line_out <= next_line;
      end
   end

endmodule

// ==== core/ledfc_regs.sv ====
// ledfc_regs: led driver function-control register bank behind a wishbone slave
//
// Functional notes
// RQ1: bit 1 picks low or high current ceiling
// RQ2: bit 14 reverses upper line order, reset one
// RQ3: bits 16-18 enable fine range per colour
// RQ4: bits 32-34 enable coarse range per colour
// RQ5: bits 19-21 pick slow or fast turn-off
// RQ6: two-bit turn-on slew per colour, reset 01
// RQ7: bits 38-35 first line dim, code plus one
// RQ8: bit 39 enables on/off channel isolation
// RQ9: bits 43-40 boost level, reset 1000
// RQ10: boost applies only when bit 44 set
// RQ11: reserved bits read fixed, ignore writes
// RQ12: six-bit open-load row select, reset zero
module ledfc_regs #(
   parameter int ADDR_W = ledfc_pkg::ADDR_W,
   parameter int DATA_W = ledfc_pkg::DATA_W,
   parameter int LINE_W = ledfc_pkg::LINE_W
) (
   // clock and reset
   input  wire logic                    mclk,
   input  wire logic                    nrst,
   // wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [ADDR_W-1:0]       wb_adr_i,
   input  wire logic [DATA_W/8-1:0]     wb_sel_i,
   input  wire logic [DATA_W-1:0]       wb_dat_i,
   output logic      [DATA_W-1:0]       wb_dat_o,
   output logic                         wb_ack_o,
   // scan sequencer
   input  wire logic [LINE_W-1:0]       scan_line_in,
   output logic      [LINE_W-1:0]       scan_line_out,
   // analog tuning controls
   output ledfc_pkg::ledfc_tuning_s     tuning,
   output logic      [4:0]              first_line_dim_level,
   output logic      [4:0]              isolation_boost_applied,
   // open-load reporting
   output logic      [5:0]              open_load_row_select
);

   localparam int REG_W = ledfc_pkg::REG_W;       // control register width
   localparam int NBYTE = DATA_W / 8;             // byte lanes

   // register storage
   logic [REG_W-1:0] tune;                        // output tuning control
   logic [REG_W-1:0] lsel;                        // open load line select

   // bus handshake
   logic             take_read;                   // capture read data now
   logic             take_write;                  // commit write now
   logic [DATA_W-1:0] lane_mask;                  // byte enables widened to bits
   logic [DATA_W-1:0] rd_word;                    // read mux result

   // write merge
   logic [REG_W-1:0] wr_image;                    // bus data placed on the 48 bits
   logic [REG_W-1:0] wr_bits;                     // bits that the write touches
   logic [REG_W-1:0] next_tune;                   // tuning after this write
   logic [REG_W-1:0] next_lsel;                   // line select after this write
   logic             hit_tune;                    // address hits tuning windows
   logic             hit_lsel;                    // address hits line select windows
   logic             hi_half;                     // upper 16-bit window addressed

   // derived levels
   logic [5:0]       next_dim;                    // dim code plus one
   logic [5:0]       next_boost;                  // boost code plus one
   logic [DATA_W-1:0] status_word;                // composed status value

   // wishbone handshake
   ledfc_wb_slave u_wb (
      .mclk       (mclk),
      .nrst       (nrst),
      .wb_cyc_i   (wb_cyc_i),
      .wb_stb_i   (wb_stb_i),
      .wb_we_i    (wb_we_i),
      .wb_ack_o   (wb_ack_o),
      .take_read  (take_read),
      .take_write (take_write)
   );

   // scan line translation for the stacked pair
   ledfc_scan_map #(
      .LINE_W (LINE_W)
   ) u_map (
      .mclk     (mclk),
      .nrst     (nrst),
      .reverse  (tune[ledfc_pkg::SCAN_POS]),   // RQ2
      .line_in  (scan_line_in),
      .line_out (scan_line_out)
   );

   // widen each byte enable to eight bit enables
   genvar gi;
   generate
      for (gi = 0; gi < NBYTE; gi++) begin : g_lane
         assign lane_mask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
      end
   endgenerate

   // address decode of the four register windows
   always_comb begin
      hit_tune = (wb_adr_i == ledfc_pkg::OFS_TUNE_LO) || (wb_adr_i == ledfc_pkg::OFS_TUNE_HI);
      hit_lsel = (wb_adr_i == ledfc_pkg::OFS_LSEL_LO) || (wb_adr_i == ledfc_pkg::OFS_LSEL_HI);
      hi_half  = (wb_adr_i == ledfc_pkg::OFS_TUNE_HI) || (wb_adr_i == ledfc_pkg::OFS_LSEL_HI);
   end

   // place the bus word on the low or high part of a 48-bit register
   always_comb begin
      wr_image = '0;
      wr_bits  = '0;
      if (hi_half) begin
         // only the low 16 bits of the upper window exist
         wr_image[REG_W-1:DATA_W] = wb_dat_i[REG_W-DATA_W-1:0];
         wr_bits[REG_W-1:DATA_W]  = lane_mask[REG_W-DATA_W-1:0];
      end else begin
         wr_image[DATA_W-1:0] = wb_dat_i;
         wr_bits[DATA_W-1:0]  = lane_mask;
      end
   end

   // merged values; reserved bits forced back to their fixed image
   always_comb begin
      next_tune = (wr_image & wr_bits) | (tune & ~wr_bits);
      next_tune = (next_tune & ledfc_pkg::TUNE_WMASK) |
                  (ledfc_pkg::TUNE_RST & ~ledfc_pkg::TUNE_WMASK);   // RQ11
      next_lsel = (wr_image & wr_bits) | (lsel & ~wr_bits);
      next_lsel = (next_lsel & ledfc_pkg::LSEL_WMASK) |
                  (ledfc_pkg::LSEL_RST & ~ledfc_pkg::LSEL_WMASK);
   end

   // tuning register: reset image carries every field default
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tune <= ledfc_pkg::TUNE_RST;             // RQ1 RQ2 RQ6 RQ9 RQ11
      end else if (take_write && hit_tune) begin
         tune <= next_tune;                       // RQ11
      end
   end

   // line select register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lsel <= ledfc_pkg::LSEL_RST;             // RQ12
      end else if (take_write && hit_lsel) begin
         lsel <= next_lsel;                       // RQ12
      end
   end

   // decoded tuning fields, registered outputs
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tuning <= '0;
         tuning.upper_scan_order_reverse <= 1'b1;
         tuning.red_turnon_slew          <= ledfc_pkg::ledfc_slew_slow;
         tuning.green_turnon_slew        <= ledfc_pkg::ledfc_slew_slow;
         tuning.blue_turnon_slew         <= ledfc_pkg::ledfc_slew_slow;
      end else begin
         // zero selects the lower ceiling, one the higher
         tuning.current_ceiling_select   <= tune[ledfc_pkg::CEIL_POS];        // RQ1
         tuning.upper_scan_order_reverse <= tune[ledfc_pkg::SCAN_POS];        // RQ2
         tuning.fine_range_enable        <= tune[ledfc_pkg::FINE_POS +: 3];   // RQ3
         // zero slow, one fast
         tuning.red_turnoff_slew   <= tune[ledfc_pkg::TOFF_POS];              // RQ5
         tuning.green_turnoff_slew <= tune[ledfc_pkg::TOFF_POS+1];            // RQ5
         tuning.blue_turnoff_slew  <= tune[ledfc_pkg::TOFF_POS+2];            // RQ5
         // slowest, slow, fast, fastest
         tuning.red_turnon_slew   <= ledfc_pkg::ledfc_slew_e'(tune[ledfc_pkg::TON_POS +: 2]);   // RQ6
         tuning.green_turnon_slew <= ledfc_pkg::ledfc_slew_e'(tune[ledfc_pkg::TON_POS+2 +: 2]); // RQ6
         tuning.blue_turnon_slew  <= ledfc_pkg::ledfc_slew_e'(tune[ledfc_pkg::TON_POS+4 +: 2]); // RQ6
         tuning.coarse_range_enable <= tune[ledfc_pkg::COARSE_POS +: 3];      // RQ4
         tuning.on_off_channel_isolation_enable <= tune[ledfc_pkg::ISO_POS];  // RQ8
      end
   end

   // level arithmetic: code n means level n+1
   always_comb begin
      next_dim = 6'({2'b00, tune[ledfc_pkg::DIM_POS +: ledfc_pkg::CODE_W]}) + 6'h01;     // RQ7
      next_boost = 6'h00;
      if (tune[ledfc_pkg::BOOSTEN_POS]) begin
         // boost only counts while its enable is set
         next_boost = 6'({2'b00, tune[ledfc_pkg::BOOST_POS +: ledfc_pkg::CODE_W]}) + 6'h01; // RQ9 RQ10
      end
   end

   // applied levels and row select, registered outputs
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         first_line_dim_level    <= 5'h01;
         isolation_boost_applied <= 5'h00;
         open_load_row_select    <= 6'h00;
      end else begin
         first_line_dim_level    <= next_dim[4:0];                           // RQ7
         isolation_boost_applied <= next_boost[4:0];                         // RQ10
         open_load_row_select    <= lsel[ledfc_pkg::ROW_POS +: ledfc_pkg::ROW_W]; // RQ12
      end
   end

   // status word from the block's own applied state
   always_comb begin
      status_word = '0;
      status_word[ledfc_pkg::ST_BOOST_POS +: 5] = isolation_boost_applied;
      status_word[ledfc_pkg::ST_DIM_POS +: 5]   = first_line_dim_level;
      status_word[ledfc_pkg::ST_LINE_POS +: LINE_W] = scan_line_out;
      status_word[ledfc_pkg::ST_CEIL_POS]       = tuning.current_ceiling_select;
   end

   // read mux; unmapped addresses read as zero
   always_comb begin
      rd_word = '0;
      case (wb_adr_i)
         ledfc_pkg::OFS_TUNE_LO: begin
            rd_word = tune[DATA_W-1:0];           // RQ11
         end
         ledfc_pkg::OFS_TUNE_HI: begin
            rd_word[REG_W-DATA_W-1:0] = tune[REG_W-1:DATA_W];
         end
         ledfc_pkg::OFS_LSEL_LO: begin
            rd_word = lsel[DATA_W-1:0];
         end
         ledfc_pkg::OFS_LSEL_HI: begin
            rd_word[REG_W-DATA_W-1:0] = lsel[REG_W-1:DATA_W];
         end
         ledfc_pkg::OFS_STATUS: begin
            rd_word = status_word;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // read data captured in the request cycle, valid with ack
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wb_dat_o <= '0;
      end else if (take_read) begin
         wb_dat_o <= rd_word;
      end
   end

endmodule

// ==== verif/ledfc_regs_chk.sv ====
// ledfc_regs_chk: bus handshake and field relation checks on the register bank ports
module ledfc_regs_chk #(
   parameter int ADDR_W = ledfc_pkg::ADDR_W,
   parameter int DATA_W = ledfc_pkg::DATA_W,
   parameter int LINE_W = ledfc_pkg::LINE_W
) (
   // clock and reset
   input wire logic                     mclk,
   input wire logic                     nrst,
   // wishbone
   input wire logic                     wb_cyc_i,
   input wire logic                     wb_stb_i,
   input wire logic                     wb_we_i,
   input wire logic [ADDR_W-1:0]        wb_adr_i,
   input wire logic [DATA_W-1:0]        wb_dat_o,
   input wire logic                     wb_ack_o,
   // derived outputs
   input wire logic [LINE_W-1:0]        scan_line_in,
   input wire logic [LINE_W-1:0]        scan_line_out,
   input wire ledfc_pkg::ledfc_tuning_s tuning,
   input wire logic [4:0]               first_line_dim_level,
   input wire logic [4:0]               isolation_boost_applied,
   input wire logic [5:0]               open_load_row_select
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // read answers per window
   logic rd_lo;
   logic rd_hi;
   logic rd_ls;
   logic rev;
   assign rd_lo = wb_ack_o && !wb_we_i && wb_adr_i == ledfc_pkg::OFS_TUNE_LO;
   assign rd_hi = wb_ack_o && !wb_we_i && wb_adr_i == ledfc_pkg::OFS_TUNE_HI;
   assign rd_ls = wb_ack_o && !wb_we_i && wb_adr_i == ledfc_pkg::OFS_LSEL_LO;
   assign rev   = tuning.upper_scan_order_reverse;
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in the next cycle");
   a_lo_reserved: assert property (rd_lo |-> wb_dat_o[0] == 1'b0 && wb_dat_o[13:2] == 12'h00F
      && wb_dat_o[15] == 1'b0 && wb_dat_o[31:28] == 4'h0) else $error("reserved low bits wrong");
   a_ceil_order: assert property (rd_lo |-> tuning.current_ceiling_select == wb_dat_o[1]
      && rev == wb_dat_o[14]) else $error("ceiling or order output differs from register");
   a_slew_fields: assert property (rd_lo |-> {tuning.blue_turnon_slew, tuning.green_turnon_slew,
      tuning.red_turnon_slew, tuning.blue_turnoff_slew, tuning.green_turnoff_slew, tuning.red_turnoff_slew,
      tuning.fine_range_enable} == wb_dat_o[27:16]) else $error("fine or slew outputs differ from register");
   a_hi_fields: assert property (rd_hi |-> tuning.coarse_range_enable == wb_dat_o[2:0]
      && tuning.on_off_channel_isolation_enable == wb_dat_o[7] && wb_dat_o[31:13] == 19'h0_0000)
      else $error("coarse or isolation output wrong");
   a_dim_level: assert property (rd_hi |-> first_line_dim_level == {1'b0, wb_dat_o[6:3]} + 5'h01)
      else $error("dim level not code plus one");
   a_boost_gate: assert property (rd_hi |-> isolation_boost_applied ==
      (wb_dat_o[12] ? {1'b0, wb_dat_o[11:8]} + 5'h01 : 5'h00)) else $error("boost level wrong");
   a_row_select: assert property (rd_ls |-> open_load_row_select == wb_dat_o[5:0]
      && wb_dat_o[31:6] == 26'h000_0000) else $error("row select mismatch");
   a_scan_mirror: assert property (rev && scan_line_in[4] ##1 rev |->
      scan_line_out == {1'b1, ~$past(scan_line_in[3:0])}) else $error("upper line not mirrored");
   a_scan_pass: assert property (!scan_line_in[4] |=> scan_line_out == $past(scan_line_in))
      else $error("lower line altered");
   // main scenarios reached
   c_boost_on: cover property (rd_hi && wb_dat_o[12]);
   c_row_top: cover property (rd_ls && wb_dat_o[5:0] == 6'h3F);
   c_mirror: cover property (rev && scan_line_in == 5'h10);
endmodule

bind ledfc_regs ledfc_regs_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .LINE_W(LINE_W)) u_chk (
   .mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scan_line_in(scan_line_in),
   .scan_line_out(scan_line_out), .tuning(tuning), .first_line_dim_level(first_line_dim_level),
   .isolation_boost_applied(isolation_boost_applied), .open_load_row_select(open_load_row_select));

// ==== verif/ledfc_host_model.sv ====
// ledfc_host_model: wishbone master standing in for the configuring controller
module ledfc_host_model (
   // clock
   input  wire logic        mclk,
   // wishbone master side
   output logic             cyc,
   output logic             stb,
   output logic             we,
   output logic [4:0]       adr,
   output logic [3:0]       sel,
   output logic [31:0]      dat,
   input  wire logic        ack,
   input  wire logic [31:0] rdat
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus from time zero
   initial {cyc, stb, we, adr, sel, dat} = '0;
   // one classic cycle; request held until ack is sampled, ok low on timeout
   task automatic xfer(input logic w, input logic [4:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] q, output bit ok);
      int n;
      ok = 1'b0;
      q = '0;
      @(posedge mclk);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge mclk);
         if (ack === 1'b1) begin
            ok = 1'b1;
            q = rdat;
         end
      end
      {cyc, stb} <= 2'b00;
      @(posedge mclk);
   endtask
endmodule

// ==== verif/tb_ledfc_regs.sv ====
// tb_ledfc_regs: self-checking bench for the led function-control register bank
module tb_ledfc_regs;
   timeunit 1ns;
   timeprecision 1ns;
   // clock, reset and port signals
   logic                     mclk = 1'b0;
   logic                     nrst = 1'b0;
   logic                     cyc, stb, we, ack;
   logic [4:0]               adr, dim, boost, scan_out;
   logic [4:0]               scan_in = 5'h00;
   logic [3:0]               sel;
   logic [31:0]              dat_w, dat_r, q;
   logic [5:0]               row;
   ledfc_pkg::ledfc_tuning_s tuning;
   int                       err_total = 0;
   int                       cmp_count = 0;
   bit                       ok;
   logic [47:0]              pats [5] = '{48'hFFFF_FFFF_FFFF, 48'h0000_0000_0000, 48'h1F78_0A95_4002,
                                          48'h1087_0568_BFFD, 48'h0F00_0000_0000};
   always #25 mclk = ~mclk;
   // design and the controller model
   ledfc_regs dut_u (.mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .scan_line_in(scan_in),
      .scan_line_out(scan_out), .tuning(tuning), .first_line_dim_level(dim),
      .isolation_boost_applied(boost), .open_load_row_select(row));
   ledfc_host_model u_host (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat_w),
      .ack(ack), .rdat(dat_r));
   // counts and verdict
   task automatic print_verdict();
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // single comparison point
   task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // bus cycle; a missing ack ends the run
   task automatic bus(logic w, logic [4:0] a, logic [3:0] s, logic [31:0] d);
      u_host.xfer(w, a, s, d, q, ok);
      if (!ok) begin
         err_total++;
         print_verdict();
      end
   endtask
   task automatic rd(logic [4:0] a, logic [31:0] exp, string nm);
      bus(1'b0, a, 4'hF, 32'h0000_0000);
      chk(nm, {16'h0000, q}, {16'h0000, exp});
   endtask
   // tuning struct image of a register value
   function automatic logic [17:0] tn(logic [47:0] v);
      return {v[1], v[14], v[18:16], v[19], v[20], v[21], v[23:22], v[25:24], v[27:26], v[34:32], v[39]};
   endfunction
   // reset image on the bus and at the outputs
   task automatic t_reset();
      rd(ledfc_pkg::OFS_TUNE_LO, 32'h0540_403C, "tune_lo");
      rd(ledfc_pkg::OFS_TUNE_HI, 32'h0000_0800, "tune_hi");
      rd(ledfc_pkg::OFS_LSEL_LO, 32'h0000_0000, "lsel_lo");
      rd(ledfc_pkg::OFS_STATUS, 32'h0000_0020, "status");
      chk("tuning", 48'(tuning), {30'h0, 18'h1_0150});
      chk("dim", 48'(dim), 48'h0000_0000_0001);
      chk("boost", 48'(boost), 48'h0000_0000_0000);
   endtask
   // field patterns written whole, read back and seen at the outputs
   task automatic t_patterns();
      logic [47:0] e;
      foreach (pats[i]) begin
         e = (pats[i] & ledfc_pkg::TUNE_WMASK) | (ledfc_pkg::TUNE_RST & ~ledfc_pkg::TUNE_WMASK);
         bus(1'b1, ledfc_pkg::OFS_TUNE_LO, 4'hF, pats[i][31:0]);
         bus(1'b1, ledfc_pkg::OFS_TUNE_HI, 4'hF, {16'h0000, pats[i][47:32]});
         repeat (2) @(posedge mclk);
         rd(ledfc_pkg::OFS_TUNE_LO, e[31:0], "tune_lo");
         rd(ledfc_pkg::OFS_TUNE_HI, {16'h0000, e[47:32]}, "tune_hi");
         chk("tuning", 48'(tuning), 48'(tn(e)));
         chk("dim", 48'(dim), 48'(e[38:35]) + 48'h1);
         chk("boost", 48'(boost), e[44] ? 48'(e[43:40]) + 48'h1 : 48'h0);
      end
   endtask
   // one byte lane alone, then unmapped space
   task automatic t_lanes();
      bus(1'b1, ledfc_pkg::OFS_TUNE_LO, 4'hF, 32'h0000_0000);
      bus(1'b1, ledfc_pkg::OFS_TUNE_LO, 4'h4, 32'hFFFF_FFFF);
      rd(ledfc_pkg::OFS_TUNE_LO, 32'h00FF_003C, "lane2");
      bus(1'b1, 5'h14, 4'hF, 32'hFFFF_FFFF);
      rd(5'h14, 32'h0000_0000, "unmapped");
   endtask
   // row select top value, reserved upper half, single lane
   task automatic t_row();
      bus(1'b1, ledfc_pkg::OFS_LSEL_LO, 4'hF, 32'hFFFF_FFFF);
      bus(1'b1, ledfc_pkg::OFS_LSEL_HI, 4'hF, 32'hFFFF_FFFF);
      repeat (2) @(posedge mclk);
      rd(ledfc_pkg::OFS_LSEL_LO, 32'h0000_003F, "lsel_lo");
      rd(ledfc_pkg::OFS_LSEL_HI, 32'h0000_0000, "lsel_hi");
      chk("row", 48'(row), 48'h3F);
      bus(1'b1, ledfc_pkg::OFS_LSEL_LO, 4'h1, 32'h0000_0020);
      repeat (2) @(posedge mclk);
      chk("row", 48'(row), 48'h20);
   endtask
   // line mapping at the boundaries in both orders
   task automatic t_scan();
      logic [4:0] ln;
      for (int r = 0; r < 2; r++) begin
         bus(1'b1, ledfc_pkg::OFS_TUNE_LO, 4'hF, r ? 32'h0000_4000 : 32'h0000_0000);
         repeat (2) @(posedge mclk);
         for (int i = 0; i < 4; i++) begin
            ln = 5'((i / 2) * 16 + (i % 2) * 15);
            scan_in <= ln;
            repeat (2) @(posedge mclk);
            chk("scan", 48'(scan_out), 48'((r == 1 && ln[4]) ? {1'b1, ~ln[3:0]} : ln));
         end
      end
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      t_patterns();
      t_lanes();
      t_row();
      t_scan();
      print_verdict();
   end
endmodule
